/* File: core/rcr_radio_ctrl.sv */
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_consts.svh"

// Functional notes
// [RQ1] Six pin bits, reset zero, top two reserved
// [RQ2] Direction one drives pin, zero is input
// [RQ3] Sleep bit sleeps device then self-clears
// [RQ4] Nine-bit wake count split across two registers
// [RQ5] Reset bit holds RF machine in reset
// [RQ6] Host pulses reset, waits 192 us
// [RQ7] Bit one forces transmit state
// [RQ8] Bit zero forces receive state
// [RQ9] Host writes 0x06 then 0x02 for transmit
// [RQ10] Decrypt bit starts job, clears when done
// [RQ11] Encrypt bit starts job, clears when done
// [RQ12] Bits 5-3 pick slot two suite
// [RQ13] Bits 2-0 pick slot one suite
// [RQ14] Rate bit selects turbo or standard rate
// [RQ15] Decode bit inverts received symbol sign
// [RQ16] Host keeps reserved bits written zero
// [RQ17] Bits 7-6 pick channel assessment mode
// [RQ18] Bits 5-2 hold carrier sense threshold
// [RQ19] Port read mixes pins and output latch
module rcr_radio_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // General purpose pins
  input  wire logic [5:0]  gpio_in_i,
  output logic      [5:0]  gpio_out_o,
  output logic      [5:0]  gpio_oe_o,
  // Sleep and oscillator
  output logic             sleep_req_o,
  output logic      [8:0]  wake_count_o,
  // RF state machine control
  output logic             rf_sm_reset_o,
  output logic             force_tx_o,
  output logic             force_rx_o,
  // Security engine
  input  wire logic        sec_done_i,
  output logic             decrypt_go_o,
  output logic             encrypt_go_o,
  output logic      [2:0]  slot2_suite_o,
  output logic      [2:0]  slot1_suite_o,
  // Baseband
  output logic             turbo_o,
  output logic             rx_invert_o,
  output logic      [1:0]  cca_mode_o,
  output logic      [3:0]  cs_threshold_o
);

  // ==========================================================
  // Address decode
  // Word index of a byte address; low bits are ignored
  function automatic logic [5:0] rcr_index(input logic [7:0] adr);
    rcr_index = adr[7:2];
  endfunction : rcr_index

  rcr_pkg::rcr_regs_s q;      // Registered state
  rcr_pkg::rcr_regs_s d;      // Next state
  logic        req;           // New bus cycle, not yet answered
  logic        wr;            // Write to byte lane zero
  logic [5:0]  idx;           // Register index
  logic [7:0]  wbyte;         // Write data byte
  logic [5:0]  port_view;     // Port as software reads it
  logic        sleep_go;      // Sleep command written
  logic        dec_go;        // Decrypt command written
  logic        enc_go;        // Encrypt command written
  logic        sleep_busy;    // Sleep bit, one cycle
  logic        dec_busy;      // Decrypt in progress
  logic        enc_busy;      // Encrypt in progress

  rcr_pin_if #(.N(6)) pins ();  // Carrier to pin port

  assign idx   = rcr_index(wb_adr_i);
  assign wbyte = wb_dat_i[7:0];
  assign req   = wb_cyc_i & wb_stb_i & ~q.ack;
  // Narrow registers live in byte lane zero only
  assign wr    = req & wb_we_i & wb_sel_i[0];

  // Inputs show the pad, outputs show the latch
  assign port_view = (q.dir & q.port)
                   | (~q.dir & pins.level);  // RQ19

  // Command strobes
  assign sleep_go = wr && (idx == `RCR_IDX_SLEEP)
                 && wbyte[`RCR_BIT_SLEEP];
  assign dec_go   = wr && (idx == `RCR_IDX_SEC)
                 && wbyte[`RCR_BIT_DEC];
  assign enc_go   = wr && (idx == `RCR_IDX_SEC)
                 && wbyte[`RCR_BIT_ENC];

  // ==========================================================
  // Next state of the register bank
  always_comb begin
    d       = q;
    // Ack one cycle after request, dropped the next
    d.ack   = req;
    d.rdata = 8'h00;
    // Read data; unmapped and reserved bits read zero
    if (req && !wb_we_i) begin
      case (idx)
        `RCR_IDX_PORT: begin
          d.rdata = {2'b00, port_view};  // RQ1 RQ19
        end
        `RCR_IDX_DIR: begin
          d.rdata = {2'b00, q.dir};
        end
        `RCR_IDX_SLEEP: begin
          // Sleep bit is write-only
          d.rdata = {1'b0, q.wake[6:0]};
        end
        `RCR_IDX_RF_MODE_CONTROL: begin
          d.rdata = {3'b000, q.wake[8:7], q.rf_rst, q.ftx, q.frx};
        end
        `RCR_IDX_SEC: begin
          // Command bits read back busy status
          d.rdata = {dec_busy, enc_busy, q.suite2, q.suite1};
        end
        `RCR_IDX_RATE: begin
          d.rdata = {7'h00, q.turbo};
        end
        `RCR_IDX_DECODE: begin
          d.rdata = {5'h00, q.rxinv, 2'b00};
        end
        `RCR_IDX_ASSESS: begin
          d.rdata = {q.cca, q.csth, 2'b00};
        end
        default: begin
          d.rdata = 8'h00;
        end
      endcase
    end
    // Writes; reserved bits are dropped
    if (wr) begin
      case (idx)
        `RCR_IDX_PORT: begin
          // Latch all; only output pins are driven
          d.port = wbyte[5:0];  // RQ1 RQ19
        end
        `RCR_IDX_DIR: begin
          d.dir = wbyte[5:0];  // RQ2
        end
        `RCR_IDX_SLEEP: begin
          d.wake[6:0] = wbyte[6:0];  // RQ4
        end
        `RCR_IDX_RF_MODE_CONTROL: begin
          d.wake[8:7] = wbyte[4:3];  // RQ4
          d.rf_rst    = wbyte[`RCR_BIT_RF_MACHINE_RESET];  // RQ5
          d.ftx       = wbyte[`RCR_BIT_FTX];  // RQ7
          d.frx       = wbyte[`RCR_BIT_FRX];  // RQ8
        end
        `RCR_IDX_SEC: begin
          d.suite2 = rcr_pkg::rcr_suite_e'(wbyte[5:3]);  // RQ12
          d.suite1 = rcr_pkg::rcr_suite_e'(wbyte[2:0]);  // RQ13
        end
        `RCR_IDX_RATE: begin
          d.turbo = wbyte[`RCR_BIT_TURBO];  // RQ14
        end
        `RCR_IDX_DECODE: begin
          d.rxinv = wbyte[`RCR_BIT_RXINV];  // RQ15
        end
        `RCR_IDX_ASSESS: begin
          d.cca  = rcr_pkg::rcr_cca_e'(wbyte[7:6]);  // RQ17
          d.csth = wbyte[5:2];  // RQ18
        end
        default: begin
          d.port = q.port;
        end
      endcase
    end
  end

  // ==========================================================
  // State register with documented reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q        <= '0;
      q.port   <= `RCR_RST_PINS;  // RQ1
      q.dir    <= `RCR_RST_PINS;  // RQ2
      q.wake   <= `RCR_RST_WAKE;
      q.suite2 <= rcr_pkg::RCR_SUITE_NONE;
      q.suite1 <= rcr_pkg::RCR_SUITE_NONE;
      q.cca    <= rcr_pkg::rcr_cca_e'(`RCR_RST_CCA_MODE);  // RQ17
      q.csth   <= `RCR_RST_CS_TH;  // RQ18
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Command bits
  // Sleep bit clears itself the cycle after it is set
  rcr_oneshot u_sleep (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (sleep_go),
    .done_i  (sleep_busy),  // RQ3
    .busy_o  (sleep_busy)
  );

  // Security jobs clear when the engine reports done
  rcr_oneshot u_decrypt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (dec_go),
    .done_i  (sec_done_i),  // RQ10
    .busy_o  (dec_busy)
  );

  rcr_oneshot u_encrypt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (enc_go),
    .done_i  (sec_done_i),  // RQ11
    .busy_o  (enc_busy)
  );

  // ==========================================================
  // Pin port
  assign pins.dir = q.dir;
  assign pins.out = q.port;

  rcr_pin_port u_pins (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .pin_i    (gpio_in_i),
    .pin_o    (gpio_out_o),
    .pin_oe_o (gpio_oe_o),
    .bus      (pins)
  );

  // ==========================================================
  // Outputs, all from flip-flops
  assign wb_ack_o       = q.ack;
  assign wb_dat_o       = {24'h000000, q.rdata};
  assign sleep_req_o    = sleep_busy;
  assign wake_count_o   = q.wake;
  assign rf_sm_reset_o  = q.rf_rst;
  assign force_tx_o     = q.ftx;
  assign force_rx_o     = q.frx;
  assign decrypt_go_o   = dec_busy;
  assign encrypt_go_o   = enc_busy;
  assign slot2_suite_o  = q.suite2;
  assign slot1_suite_o  = q.suite1;
  assign turbo_o        = q.turbo;
  assign rx_invert_o    = q.rxinv;
  assign cca_mode_o     = q.cca;
  assign cs_threshold_o = q.csth;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  pins_reset_input_a: assert property (  // RQ2
    $past(rst_i) |-> ##1 gpio_oe_o == 6'h00)
    else $error("pins not inputs after reset");
  port_read_a: assert property (  // RQ19
    req && !wb_we_i && idx == `RCR_IDX_PORT
    |=> wb_ack_o && wb_dat_o == {26'h0, $past(port_view)})
    else $error("port read data wrong");
  sleep_pulse_a: assert property (  // RQ3
    sleep_go |=> sleep_req_o ##1 !sleep_req_o)
    else $error("sleep bit not self clearing");
  wake_count_a: assert property (  // RQ4
    wr && idx == `RCR_IDX_SLEEP
    |=> wake_count_o[6:0] == $past(wbyte[6:0]))
    else $error("wake count low bits wrong");
  rf_reset_hold_a: assert property (  // RQ5
    wr && idx == `RCR_IDX_RF_MODE_CONTROL
    |=> rf_sm_reset_o == $past(wbyte[2])
        && wake_count_o[8:7] == $past(wbyte[4:3]))
    else $error("rf control write wrong");
  force_tx_a: assert property (  // RQ7
    wr && idx == `RCR_IDX_RF_MODE_CONTROL |=> force_tx_o == $past(wbyte[1]))
    else $error("force transmit wrong");
  force_rx_a: assert property (  // RQ8
    wr && idx == `RCR_IDX_RF_MODE_CONTROL |=> force_rx_o == $past(wbyte[0]))
    else $error("force receive wrong");
  decrypt_hold_a: assert property (  // RQ10
    decrypt_go_o && !sec_done_i |=> decrypt_go_o)
    else $error("decrypt cleared early");
  suite_write_a: assert property (  // RQ12
    wr && idx == `RCR_IDX_SEC
    |=> slot2_suite_o == $past(wbyte[5:3])
        && slot1_suite_o == $past(wbyte[2:0]))  // RQ13
    else $error("suite select wrong");
  baseband_write_a: assert property (  // RQ14
    wr && idx == `RCR_IDX_RATE |=> turbo_o == $past(wbyte[0]))
    else $error("rate select wrong");
  invert_write_a: assert property (  // RQ15
    wr && idx == `RCR_IDX_DECODE |=> rx_invert_o == $past(wbyte[2]))
    else $error("decode invert wrong");
  assess_write_a: assert property (  // RQ17
    wr && idx == `RCR_IDX_ASSESS
    |=> cca_mode_o == $past(wbyte[7:6])
        && cs_threshold_o == $past(wbyte[5:2]))  // RQ18
    else $error("assessment fields wrong");
  ack_once_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

endmodule : rcr_radio_ctrl

`default_nettype wire

/* File: inc/rcr_consts.svh */
`ifndef RCR_CONSTS_SVH
`define RCR_CONSTS_SVH

// ==========================================================
// Register indexes (byte address is four times the index)
`define RCR_IDX_PORT     6'h33
`define RCR_IDX_DIR      6'h34
`define RCR_IDX_SLEEP    6'h35
`define RCR_IDX_RF_MODE_CONTROL    6'h36
`define RCR_IDX_SEC      6'h37
`define RCR_IDX_RATE     6'h38
`define RCR_IDX_DECODE   6'h39
`define RCR_IDX_ASSESS   6'h3A

// ==========================================================
// Field positions
`define RCR_BIT_SLEEP    7
`define RCR_BIT_DEC      7
`define RCR_BIT_ENC      6
`define RCR_BIT_RF_MACHINE_RESET    2
`define RCR_BIT_FTX      1
`define RCR_BIT_FRX      0
`define RCR_BIT_TURBO    0
`define RCR_BIT_RXINV    2

// ==========================================================
// Reset values
`define RCR_RST_PINS     6'h00
`define RCR_RST_WAKE     9'h000
`define RCR_RST_CCA_MODE 2'h1
`define RCR_RST_CS_TH    4'h2

`endif

/* File: inc/rcr_pkg.sv */
`default_nettype none

package rcr_pkg;

  // ==========================================================
  // Security suite codes of a guaranteed-slot FIFO
  typedef enum logic [2:0] {
    RCR_SUITE_NONE    = 3'h0,
    RCR_SUITE_CTR     = 3'h1,
    RCR_SUITE_CCM128  = 3'h2,
    RCR_SUITE_CCM64   = 3'h3,
    RCR_SUITE_CCM32   = 3'h4,
    RCR_SUITE_MAC128  = 3'h5,
    RCR_SUITE_MAC64   = 3'h6,
    RCR_SUITE_MAC32   = 3'h7
  } rcr_suite_e;

  // Channel assessment modes; code zero is reserved
  typedef enum logic [1:0] {
    RCR_CCA_RSVD  = 2'h0,
    RCR_CCA_CS    = 2'h1,
    RCR_CCA_ED    = 2'h2,
    RCR_CCA_CS_ED = 2'h3
  } rcr_cca_e;

  // ==========================================================
  // Register bank state
  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
    logic [5:0] port;
    logic [5:0] dir;
    logic [8:0] wake;
    logic       rf_rst;
    logic       ftx;
    logic       frx;
    rcr_suite_e suite2;
    rcr_suite_e suite1;
    logic       turbo;
    logic       rxinv;
    rcr_cca_e   cca;
    logic [3:0] csth;
  } rcr_regs_s;

  // Pin port state
  typedef struct packed {
    logic [5:0] meta;
    logic [5:0] lvl;
    logic [5:0] out;
    logic [5:0] oe;
  } rcr_pin_s;

  // Self-clearing command bit
  typedef struct packed {
    logic busy;
  } rcr_shot_s;

endpackage : rcr_pkg

`default_nettype wire

/* File: inc/rcr_pin_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Carrier between register bank and pin port
interface rcr_pin_if #(parameter int N = 6);
  logic [N-1:0] dir;    // One means output
  logic [N-1:0] out;    // Stored output value
  logic [N-1:0] level;  // Synchronised pin level
  modport core (output dir, output out, input level);
  modport port (input dir, input out, output level);
endinterface : rcr_pin_if

`default_nettype wire

/* File: core/rcr_oneshot.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Command bit: set by software, cleared by hardware
module rcr_oneshot (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,  // Software wrote a one
  input  wire logic done_i,   // Operation finished
  output logic      busy_o    // Bit as seen by software
);

  rcr_pkg::rcr_shot_s q;  // Registered state
  rcr_pkg::rcr_shot_s d;  // Next state

  // ==========================================================
  // Next state: a start in the finishing cycle wins
  always_comb begin
    d      = q;
    d.busy = start_i | (q.busy & ~done_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy_o = q.busy;

  // ==========================================================
  // Checks
  start_wins_a: assert property (  // RQ10
    @(posedge clk_i) disable iff (rst_i)
    start_i |=> busy_o)
    else $error("start lost");
  clear_on_done_a: assert property (  // RQ11
    @(posedge clk_i) disable iff (rst_i)
    busy_o && done_i && !start_i |=> !busy_o)
    else $error("command bit did not clear");

endmodule : rcr_oneshot

`default_nettype wire

/* File: core/rcr_pin_port.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// General purpose pins: synchroniser and drivers
module rcr_pin_port (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [5:0] pin_i,     // Pin levels from pads
  output logic      [5:0] pin_o,     // Pin drive values
  output logic      [5:0] pin_oe_o,  // High while driving
  rcr_pin_if.port         bus
);

  rcr_pkg::rcr_pin_s q;  // Registered state
  rcr_pkg::rcr_pin_s d;  // Next state

  // ==========================================================
  // Two stages before any logic sees a pad
  always_comb begin
    d      = q;
    d.meta = pin_i;
    d.lvl  = q.meta;
    d.out  = bus.out;
    d.oe   = bus.dir;  // RQ2
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_o     = q.out;
  assign pin_oe_o  = q.oe;
  assign bus.level = q.lvl;

  // ==========================================================
  // Checks
  oe_follows_dir_a: assert property (  // RQ2
    @(posedge clk_i) disable iff (rst_i)
    ##1 pin_oe_o == $past(bus.dir))
    else $error("enable does not follow direction");

endmodule : rcr_pin_port

`default_nettype wire

/* File: dv/rcr_far_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Far side: pads around the pins and the security engine
module rcr_far_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [5:0] drive_i,  // Pin drive values
  input  wire logic [5:0] oe_i,     // High while the bank drives
  input  wire logic [5:0] ext_i,    // Level other parts put on pins
  input  wire logic       busy_i,   // Either security job running
  input  wire logic [7:0] lat_i,    // Engine run time in cycles
  output logic      [5:0] pad_o,    // Resolved pad levels
  output logic            done_o    // One-cycle job finished
);
  logic [7:0] cnt_reg;  // Cycles the current job has run

  // Bank wins on driven pins; no contention is modelled
  assign pad_o = (drive_i & oe_i) | (ext_i & ~oe_i);

  // Engine: done_o rises lat_i+1 cycles after busy_i rises, one pulse per job
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_i || done_o) begin
      cnt_reg <= 8'h00;
      done_o  <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      done_o  <= (cnt_reg == lat_i);
    end
  end
endmodule : rcr_far_model

`default_nettype wire

/* File: dv/tb_radio_ctrl_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bench for the radio control register bank
module tb_radio_ctrl_register_bank;
  localparam int CAL_CYC = 38400;  // 192 us at 5 ns
  localparam int LIMIT   = 50000;  // Whole run ceiling in cycles

  logic        clk, rst, cyc, stb, we, ack, slp, rfr, ftx, frx, done, dec, enc, turbo, rxinv;
  logic [7:0]  adr, lat;
  logic [3:0]  sel, csth;
  logic [31:0] dat_w, dat_r, rd;
  logic [5:0]  pins, gout, goe, ext;
  logic [8:0]  wake;
  logic [2:0]  s2, s1;
  logic [1:0]  cca;
  int          bad_count, n_tests, slp_n, cyc_n, n;
  logic [7:0]  dflt [8] = '{8'h2A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h48};
  logic [7:0]  rfv [5] = '{8'h1E, 8'h06, 8'h02, 8'h01, 8'h00};

  rcr_radio_ctrl dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .gpio_in_i(pins), .gpio_out_o(gout), .gpio_oe_o(goe),
    .sleep_req_o(slp), .wake_count_o(wake), .rf_sm_reset_o(rfr), .force_tx_o(ftx),
    .force_rx_o(frx), .sec_done_i(done), .decrypt_go_o(dec), .encrypt_go_o(enc),
    .slot2_suite_o(s2), .slot1_suite_o(s1), .turbo_o(turbo), .rx_invert_o(rxinv),
    .cca_mode_o(cca), .cs_threshold_o(csth));

  rcr_far_model far (.clk_i(clk), .rst_i(rst), .drive_i(gout), .oe_i(goe), .ext_i(ext),
    .busy_i(dec | enc), .lat_i(lat), .pad_o(pins), .done_o(done));

  // ==========================================================
  // Clock, sleep pulse counter and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (slp === 1'b1) slp_n++;
    cyc_n++;
    if (cyc_n == LIMIT) begin
      bad_count++;
      close_out();
    end
  end

  // ==========================================================
  // Verdict
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] wd,
                    input logic [3:0] be = 4'hF);
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    sel   <= be;
    adr   <= {idx, 2'b00};
    dat_w <= {24'h0, wd};
    // Only ack or the bench ceiling ends this wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask : rd_chk

  task automatic settle();
    repeat (2) @(posedge clk);
  endtask : settle

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {cyc, stb, we} = 3'b000;
    adr = 8'h00;
    sel = 4'hF;
    dat_w = 32'h0;
    ext = 6'h2A;
    lat = 8'h06;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, port reads pads while all are inputs
    for (int i = 0; i < 8; i++) rd_chk(6'h33 + 6'(i), dflt[i]);
    chk(32'({goe, gout, cca, csth}), 32'({12'h000, 2'h1, 4'h2}));
    // Unmapped place: write ignored, reads zero
    wb(1'b1, 6'h3B, 8'hFF);
    rd_chk(6'h3B, 8'h00);
    // Rate and decode inversion, both values
    for (int v = 0; v < 2; v++) begin
      wb(1'b1, 6'h38, {7'h00, 1'(v)});
      wb(1'b1, 6'h39, {5'h00, 1'(v), 2'b00});
      settle();
      chk(32'({turbo, rxinv}), 32'({1'(v), 1'(v)}));
      rd_chk(6'h39, {5'h00, 1'(v), 2'b00});
    end
    // Byte lane zero disabled: write acked but dropped
    wb(1'b1, 6'h38, 8'h00, 4'hE);
    rd_chk(6'h38, 8'h01);
    // Every defined assessment mode with recommended threshold
    for (int m = 1; m < 4; m++) begin
      wb(1'b1, 6'h3A, {2'(m), 4'hE, 2'b00});
      settle();
      chk(32'({cca, csth}), 32'({2'(m), 4'hE}));
      rd_chk(6'h3A, {2'(m), 4'hE, 2'b00});
    end
    // Every suite code on both slots
    for (int s = 0; s < 8; s++) begin
      wb(1'b1, 6'h37, {2'b00, 3'(s), ~3'(s)});
      settle();
      chk(32'({s2, s1}), 32'({3'(s), ~3'(s)}));
      rd_chk(6'h37, {2'b00, 3'(s), ~3'(s)});
    end
    // Mixed directions: outputs drive latch, inputs read pads
    wb(1'b1, 6'h33, 8'h15);
    wb(1'b1, 6'h34, 8'h0F);
    settle();
    chk(32'({goe, gout & goe}), 32'({6'h0F, 6'h05}));
    rd_chk(6'h33, 8'h25);
    ext <= 6'h15;
    settle();
    rd_chk(6'h33, 8'h15);
    // Wake count split and RF control, host reset then transmit
    wb(1'b1, 6'h35, 8'h5F);
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 6'h36, rfv[i]);
      settle();
      chk(32'({wake, rfr, ftx, frx}), 32'({rfv[i][4:3], 7'h5F, rfv[i][2:0]}));
      rd_chk(6'h36, rfv[i]);
    end
    repeat (CAL_CYC) @(posedge clk);
    // Back-to-back sleep commands, bit reads back clear
    wb(1'b1, 6'h35, 8'hDF);
    wb(1'b1, 6'h35, 8'hDF);
    settle();
    chk(32'(slp_n), 32'h2);
    rd_chk(6'h35, 8'h5F);
    // Decrypt with quick engine, encrypt with slow engine
    for (int b = 0; b < 2; b++) begin
      lat <= b ? 8'd40 : 8'd6;
      wb(1'b1, 6'h37, (b ? 8'h40 : 8'h80) | 8'h2B);
      chk(32'({dec, enc}), b ? 32'h1 : 32'h2);
      rd_chk(6'h37, (b ? 8'h40 : 8'h80) | 8'h2B);
      n = 0;
      while ((dec | enc) !== 1'b0 && n < 100) begin
        @(posedge clk);
        n++;
      end
      settle();
      rd_chk(6'h37, 8'h2B);
    end
    // Second reset in mid-run restores defaults
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'({wake, goe, s2, s1, cca, csth}), 32'({21'h0, 2'h1, 4'h2}));
    rd_chk(6'h3A, 8'h48);
    close_out();
  end
endmodule : tb_radio_ctrl_register_bank

`default_nettype wire
